// file: rtl/dcd_map.vh
// Command codes, field positions and layout constants of the debug decoder
`ifndef DCD_MAP_VH
`define DCD_MAP_VH
`define DCD_OP_HI        7
`define DCD_OP_LO        3
`define DCD_RET_BIT      2
`define DCD_CNT_HI       1
`define DCD_CNT_LO       0
// Instruction codes with their don't-care masks (1 = compared bit)
`define DCD_ERASE_CODE   8'h10
`define DCD_ERASE_MASK   8'hfb
`define DCD_WRCFG_CODE   8'h19
`define DCD_WRCFG_MASK   8'hfb
`define DCD_RDCFG_CODE   8'h24
`define DCD_RDCFG_MASK   8'hff
`define DCD_PC_CODE      8'h28
`define DCD_PC_MASK      8'hff
`define DCD_STAT_CODE    8'h30
`define DCD_STAT_MASK    8'hfb
`define DCD_BRK_CODE     8'h3b
`define DCD_BRK_MASK     8'hfb
`define DCD_HALT_CODE    8'h44
`define DCD_HALT_MASK    8'hff
`define DCD_RES_CODE     8'h4c
`define DCD_RES_MASK     8'hff
`define DCD_INJ_CODE     8'h54
`define DCD_INJ_MASK     8'hfc
`define DCD_STEP_CODE    8'h5c
`define DCD_STEP_MASK    8'hff
`define DCD_SUB_CODE     8'h64
`define DCD_SUB_MASK     8'hfc
`define DCD_ID_CODE      8'h68
`define DCD_ID_MASK      8'hff
// Configuration byte fields
`define DCD_CFG_RESET    4'h0
`define DCD_CFG_TIMOFF   3
`define DCD_CFG_DMAP     2
`define DCD_CFG_TSUSP    1
`define DCD_CFG_INFOPG   0
`endif

// file: rtl/dcd_sync.v
// Two-flop synchroniser for the debug clock and data pins
`timescale 1ns/1ps
module dcd_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: rtl/dcd_top.v
// Debug port command decoder: serial link, decode, configuration byte
// Functional notes
// [RULE1] Write-config stores operand; read-config returns the stored byte.
// [RULE2] Status query returns one debug status byte.
// [RULE3] Mass erase requests full flash erase and lock bit clear.
// [RULE4] Any command except status query disables mass erase afterwards.
// [RULE5] Program counter readback returns two bytes, ignoring return bit.
// [RULE6] Don't-care bits of command bytes are ignored in matching.
// [RULE7] Resume restarts the CPU, only when halted.
// [RULE8] Injection runs host bytes on halted CPU, PC not advanced.
// [RULE9] Single step runs next program instruction, PC advances.
// [RULE10] Step-substitute runs host instruction instead, PC advances.
// [RULE11] Identity readback returns two bytes, ignoring return bit.
// [RULE12] Config bit 3 stops timers while set.
// [RULE13] Config bit 2 pauses DMA while set.
// [RULE14] Config bit 1 suspends timers during injected or stepped branch.
// [RULE15] Config bit 0 selects info page when set, main page otherwise.
// [RULE16] Host polls status for erase done and oscillator stability.
// [RULE17] Command byte: code bits 7-3, return bit 2, count bits 1-0.
// [RULE18] Drive on rising debug clock, sample on falling, MSB first.
// [RULE19] When locked, only erase, status and identity commands act.
// [RULE20] Status bits: erase done, idle, halted, PM0, cause, lock, osc, ovf.
// [RULE21] Config byte resets to zero; upper four bits read zero.
// [RULE22] Halt-only commands on a running CPU are ignored.
`timescale 1ns/1ps
`include "dcd_map.vh"
module dcd_top #(
  parameter [15:0] CHIP_ID = 16'ha5c3 // Arbitrary identity value
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        DBG_CLK,
  input  wire        DBG_DATA_IN,
  output reg         DBG_DATA_OUT,
  output reg         DBG_DATA_OE,
  input  wire [15:0] PROGRAM_COUNTER,
  input  wire        CPU_HALTED,
  input  wire        CPU_IDLE,
  input  wire        POWER_MODE_0,
  input  wire        HALT_BY_BREAKPOINT,
  input  wire        DEBUG_LOCK_BIT,
  input  wire        OSC_STABLE,
  input  wire        STACK_OVERFLOW,
  input  wire        ERASE_DONE,
  output reg         ERASE_REQ,
  output reg         HALT_REQ,
  output reg         RESUME_REQ,
  output reg         INJECT_REQ,
  output reg         STEP_REQ,
  output reg         SUBST_REQ,
  output reg         BRK_SET_REQ,
  output reg  [23:0] CPU_INSTR,
  output reg  [1:0]  CPU_INSTR_LEN,
  output reg  [23:0] BRK_DATA,
  output reg         TIMERS_STOP,
  output reg         DMA_PAUSE,
  output reg         TIMER_SUSPEND,
  output reg         INFO_PAGE_SELECT
);
  localparam [1:0] ST_CMD = 2'h0;
  localparam [1:0] ST_OPR = 2'h1;
  localparam [1:0] ST_RET = 2'h2;

  wire [1:0] pins_sync;
  reg        clk_prev;
  reg  [1:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shift_in;
  reg  [7:0] cmd;
  reg  [1:0] opr_left;
  reg  [1:0] opr_idx;
  reg  [23:0] opr;
  reg  [15:0] tx_word;
  reg  [1:0] tx_bytes;
  reg  [3:0] cfg;
  reg        erase_ok;

  // Link pins cross into CLK before any logic looks at them
  dcd_sync #(.W(2)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({DBG_CLK, DBG_DATA_IN}),
    .q   (pins_sync)
  );

  wire dclk     = pins_sync[1];
  wire ddata    = pins_sync[0];
  wire rise     = dclk & ~clk_prev;
  wire fall     = ~dclk & clk_prev;
  wire [7:0] rx_byte = {shift_in[6:0], ddata};
  wire byte_end = fall & (bit_cnt == 3'h7);

  // Masked compare used by every command match
  function match;
    input [7:0] c;
    input [7:0] code;
    input [7:0] mask;
    begin
      match = ((c & mask) == (code & mask)); // [RULE6]
    end
  endfunction

  wire [7:0] status = {ERASE_DONE, CPU_IDLE, CPU_HALTED, POWER_MODE_0,
                       HALT_BY_BREAKPOINT, DEBUG_LOCK_BIT, OSC_STABLE,
                       STACK_OVERFLOW}; // [RULE20]

  // Execute a fully received command
  reg        exec;
  reg [7:0]  ecmd;
  always @(posedge CLK) begin
    if (RST) begin
      exec <= 1'b0;
      ecmd <= 8'h00;
    end else begin
      exec <= 1'b0;
      if (byte_end && (state == ST_CMD) &&
          rx_byte[`DCD_CNT_HI:`DCD_CNT_LO] == 2'h0) begin
        exec <= 1'b1;
        ecmd <= rx_byte;
      end else if (byte_end && (state == ST_OPR) && opr_left == 2'h1) begin
        exec <= 1'b1;
        ecmd <= cmd;
      end
    end
  end

  wire is_erase = match(ecmd, `DCD_ERASE_CODE, `DCD_ERASE_MASK);
  wire is_wrcfg = match(ecmd, `DCD_WRCFG_CODE, `DCD_WRCFG_MASK);
  wire is_rdcfg = match(ecmd, `DCD_RDCFG_CODE, `DCD_RDCFG_MASK);
  wire is_pc    = match(ecmd, `DCD_PC_CODE, `DCD_PC_MASK);
  wire is_stat  = match(ecmd, `DCD_STAT_CODE, `DCD_STAT_MASK);
  wire is_brk   = match(ecmd, `DCD_BRK_CODE, `DCD_BRK_MASK);
  wire is_halt  = match(ecmd, `DCD_HALT_CODE, `DCD_HALT_MASK);
  wire is_res   = match(ecmd, `DCD_RES_CODE, `DCD_RES_MASK);
  wire is_inj   = match(ecmd, `DCD_INJ_CODE, `DCD_INJ_MASK);
  wire is_step  = match(ecmd, `DCD_STEP_CODE, `DCD_STEP_MASK);
  wire is_sub   = match(ecmd, `DCD_SUB_CODE, `DCD_SUB_MASK);
  wire is_id    = match(ecmd, `DCD_ID_CODE, `DCD_ID_MASK);
  wire allowed  = ~DEBUG_LOCK_BIT | is_erase | is_stat | is_id; // [RULE19]
  wire halted_ok = allowed & CPU_HALTED; // [RULE22]

  // Answer selection: two-byte readbacks ignore the return bit
  reg [15:0] next_tx_word;
  reg [1:0]  next_tx_bytes;
  always @* begin
    next_tx_word  = 16'h0000;
    next_tx_bytes = 2'h0;
    if (allowed && is_pc) begin
      next_tx_word  = PROGRAM_COUNTER; // [RULE5]
      next_tx_bytes = 2'h2;
    end else if (allowed && is_id) begin
      next_tx_word  = CHIP_ID; // [RULE11]
      next_tx_bytes = 2'h2;
    end else if (ecmd[`DCD_RET_BIT]) begin // [RULE17]
      next_tx_bytes = 2'h1;
      if (is_stat)
        next_tx_word = {status, 8'h00}; // [RULE2]
      else if (allowed && is_rdcfg)
        next_tx_word = {4'h0, cfg, 8'h00}; // [RULE1] [RULE21]
      else if (allowed && is_res)
        next_tx_word = {status, 8'h00};
      else if (allowed && (is_halt || is_inj || is_step || is_sub))
        next_tx_word = {status, 8'h00};
    end
  end

  // Serial engine: sample on falling debug clock, drive on rising
  always @(posedge CLK) begin
    if (RST) begin
      clk_prev     <= 1'b0;
      state        <= ST_CMD;
      bit_cnt      <= 3'h0;
      shift_in     <= 8'h00;
      cmd          <= 8'h00;
      opr_left     <= 2'h0;
      opr_idx      <= 2'h0;
      opr          <= 24'h000000;
      tx_word      <= 16'h0000;
      tx_bytes     <= 2'h0;
      DBG_DATA_OUT <= 1'b0;
      DBG_DATA_OE  <= 1'b0;
    end else begin
      clk_prev <= dclk;
      if (fall) begin
        shift_in <= rx_byte; // [RULE18]
        bit_cnt  <= bit_cnt + 3'h1;
      end
      if (exec && next_tx_bytes != 2'h0) begin
        state    <= ST_RET;
        tx_word  <= next_tx_word;
        tx_bytes <= next_tx_bytes;
        bit_cnt  <= 3'h0;
      end else if (byte_end) begin
        case (state)
          ST_CMD: begin
            cmd      <= rx_byte;
            opr_left <= rx_byte[`DCD_CNT_HI:`DCD_CNT_LO]; // [RULE17]
            opr_idx  <= 2'h0;
            opr      <= 24'h000000;
            if (rx_byte[`DCD_CNT_HI:`DCD_CNT_LO] != 2'h0)
              state <= ST_OPR;
          end
          ST_OPR: begin
            case (opr_idx)
              2'h0: opr[23:16] <= rx_byte;
              2'h1: opr[15:8]  <= rx_byte;
              default: opr[7:0] <= rx_byte;
            endcase
            opr_idx  <= opr_idx + 2'h1;
            opr_left <= opr_left - 2'h1;
            if (opr_left == 2'h1)
              state <= ST_CMD;
          end
          ST_RET: begin
            // Host clocks the answer out; each eighth falling edge ends an answer byte
            if (tx_bytes == 2'h1) begin
              state       <= ST_CMD;
              DBG_DATA_OE <= 1'b0;
            end
            tx_bytes <= tx_bytes - 2'h1;
            tx_word  <= {tx_word[7:0], 8'h00};
          end
          default: state <= ST_CMD;
        endcase
      end else if (rise && state == ST_RET) begin
        DBG_DATA_OE  <= 1'b1;
        DBG_DATA_OUT <= tx_word[15 - {1'b0, bit_cnt}]; // [RULE18]
      end
    end
  end

  // Last-received operand byte, used by one-operand commands
  wire [7:0] opr_last = (opr_idx == 2'h1) ? opr[23:16] :
                        (opr_idx == 2'h2) ? opr[15:8] : opr[7:0];

  // Command effects
  always @(posedge CLK) begin
    if (RST) begin
      cfg           <= `DCD_CFG_RESET; // [RULE21]
      erase_ok      <= 1'b1;
      ERASE_REQ     <= 1'b0;
      HALT_REQ      <= 1'b0;
      RESUME_REQ    <= 1'b0;
      INJECT_REQ    <= 1'b0;
      STEP_REQ      <= 1'b0;
      SUBST_REQ     <= 1'b0;
      BRK_SET_REQ   <= 1'b0;
      CPU_INSTR     <= 24'h000000;
      CPU_INSTR_LEN <= 2'h0;
      BRK_DATA      <= 24'h000000;
    end else begin
      ERASE_REQ   <= 1'b0;
      HALT_REQ    <= 1'b0;
      RESUME_REQ  <= 1'b0;
      INJECT_REQ  <= 1'b0;
      STEP_REQ    <= 1'b0;
      SUBST_REQ   <= 1'b0;
      BRK_SET_REQ <= 1'b0;
      if (exec) begin
        if (!is_stat)
          erase_ok <= 1'b0; // [RULE4]
        if (is_erase && erase_ok)
          ERASE_REQ <= 1'b1; // [RULE3]
        if (allowed && is_wrcfg)
          cfg <= opr_last[3:0]; // [RULE1]
        if (allowed && is_brk) begin
          BRK_SET_REQ <= 1'b1;
          BRK_DATA    <= opr;
        end
        if (allowed && is_halt)
          HALT_REQ <= 1'b1;
        if (halted_ok && is_res)
          RESUME_REQ <= 1'b1; // [RULE7] [RULE22]
        if (halted_ok && is_step)
          STEP_REQ <= 1'b1; // [RULE9]
        if (halted_ok && (is_inj || is_sub)) begin
          INJECT_REQ    <= is_inj; // [RULE8]
          SUBST_REQ     <= is_sub; // [RULE10]
          CPU_INSTR     <= opr;
          CPU_INSTR_LEN <= ecmd[`DCD_CNT_HI:`DCD_CNT_LO];
        end
      end
    end
  end

  // Config drives system controls straight from flops
  always @(posedge CLK) begin
    if (RST) begin
      TIMERS_STOP      <= 1'b0;
      DMA_PAUSE        <= 1'b0;
      TIMER_SUSPEND    <= 1'b0;
      INFO_PAGE_SELECT <= 1'b0;
    end else begin
      TIMERS_STOP      <= cfg[`DCD_CFG_TIMOFF]; // [RULE12]
      DMA_PAUSE        <= cfg[`DCD_CFG_DMAP]; // [RULE13]
      TIMER_SUSPEND    <= cfg[`DCD_CFG_TSUSP]; // [RULE14]
      INFO_PAGE_SELECT <= cfg[`DCD_CFG_INFOPG]; // [RULE15]
    end
  end
endmodule

// file: bench/dcd_top_asserts.sv
// Port checker for the debug command decoder
`timescale 1ns/1ps
module dcd_top_asserts (
  input wire CLK,
  input wire RST,
  input wire DBG_CLK,
  input wire DBG_DATA_OE,
  input wire CPU_HALTED,
  input wire DEBUG_LOCK_BIT,
  input wire ERASE_REQ,
  input wire HALT_REQ,
  input wire RESUME_REQ,
  input wire INJECT_REQ,
  input wire STEP_REQ,
  input wire SUBST_REQ,
  input wire BRK_SET_REQ,
  input wire TIMERS_STOP,
  input wire DMA_PAUSE,
  input wire TIMER_SUSPEND,
  input wire INFO_PAGE_SELECT
);
  wire [5:0] oth;
  wire [3:0] cfg;
  reg        used;
  assign oth = {HALT_REQ, RESUME_REQ, INJECT_REQ, STEP_REQ, SUBST_REQ,
                BRK_SET_REQ};
  assign cfg = {TIMERS_STOP, DMA_PAUSE, TIMER_SUSPEND, INFO_PAGE_SELECT};
  // Only visible effects count, so refused commands slip past this flag
  always @(posedge CLK) begin
    if (RST)
      used <= 1'b0;
    else if (|oth || |cfg)
      used <= 1'b1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_req_onehot: assert property ($onehot0({ERASE_REQ, oth}))
    else $error("Two requests at once");
  a_erase_pulse: assert property (ERASE_REQ |=> !ERASE_REQ)
    else $error("Erase pulse too long");
  // Halt state is judged on the cycle the command executed
  a_resume_halted: assert property (
    RESUME_REQ |-> $past(CPU_HALTED)) else $error("Resume while running");
  a_step_halted: assert property (
    (INJECT_REQ || STEP_REQ || SUBST_REQ) |-> $past(CPU_HALTED))
    else $error("Halted command while running");
  a_lock_silent: assert property (DEBUG_LOCK_BIT |-> oth == 6'h00)
    else $error("Command acted while locked");
  a_erase_refused: assert property (used |-> !ERASE_REQ)
    else $error("Erase after other command");
  a_reset_clear: assert property (
    $fell(RST) |-> cfg == 4'h0 && !DBG_DATA_OE)
    else $error("Outputs not clear after reset");
  a_oe_drop: assert property ($fell(DBG_DATA_OE) |-> !DBG_CLK)
    else $error("Data line released with debug clock high");
  c_erase: cover property (ERASE_REQ);
  c_resume: cover property (RESUME_REQ);
  c_answer: cover property ($rose(DBG_DATA_OE));
endmodule

bind dcd_top dcd_top_asserts dcd_top_asserts_i (
  .CLK, .RST, .DBG_CLK, .DBG_DATA_OE, .CPU_HALTED, .DEBUG_LOCK_BIT,
  .ERASE_REQ, .HALT_REQ, .RESUME_REQ, .INJECT_REQ, .STEP_REQ, .SUBST_REQ,
  .BRK_SET_REQ, .TIMERS_STOP, .DMA_PAUSE, .TIMER_SUSPEND, .INFO_PAGE_SELECT
);

// file: bench/dcd_host.sv
// Debug host model: shifts command bytes out and collects answers
`timescale 1ns/1ps
module dcd_host (
  input  wire clk,
  input  wire oe,
  input  wire dout,
  output reg  dbg_clk,
  output wire dbg_data
);
  reg drv = 1'b0;
  // Released line toggles each bit so a stale value never looks valid
  assign dbg_data = oe ? dout : drv;
  initial dbg_clk = 1'b0;
  task automatic half;
    repeat (16) @(posedge clk);
    #1;
  endtask
  task automatic xbyte(input [7:0] tx, input rel, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--) begin
      dbg_clk = 1'b1;
      drv = rel ? ~drv : tx[i];
      half;
      rx[i] = dbg_data;
      dbg_clk = 1'b0;
      half;
    end
  endtask
  task automatic cmd(input [7:0] c, input [23:0] ops, input integer n,
                     output [15:0] ret);
    integer   k;
    reg [7:0] b;
    ret = 16'h0;
    xbyte(c, 1'b0, b);
    for (k = 0; k < c[1:0]; k++)
      xbyte(ops[23-8*k -: 8], 1'b0, b);
    for (k = 0; k < n; k++) begin
      xbyte(8'h00, 1'b1, b);
      ret = {ret[7:0], b};
    end
    half;
  endtask
endmodule

// file: bench/test_debug_command_decoder.sv
// Self-checking bench for the debug command decoder
`timescale 1ns/1ps
module test_debug_command_decoder;
  localparam [15:0] ID = 16'h3c5a; // Arbitrary identity value
  reg         clk = 0;
  reg         rst = 1;
  reg  [15:0] pc = 0;
  reg  [7:0]  st = 0;
  reg  [6:0]  seen = 0;
  reg         clr = 0;
  reg  [15:0] r;
  reg  [23:0] v;
  integer     errors = 0;
  integer     checked = 0;
  integer     i;
  wire        oe, dout, dclk, ddat;
  wire [6:0]  req;
  wire [23:0] ins, brk;
  wire [1:0]  ilen;
  wire [3:0]  cfg;
  always #2.5 clk = ~clk;
  // One driver for the pulse record; tasks only request a clear
  always @(posedge clk) seen <= clr ? 7'h00 : (seen | req);
  dcd_top #(.CHIP_ID(ID)) dcd_top_i (.CLK(clk), .RST(rst),
    .DBG_CLK(dclk), .DBG_DATA_IN(ddat), .DBG_DATA_OUT(dout),
    .DBG_DATA_OE(oe), .PROGRAM_COUNTER(pc), .CPU_HALTED(st[5]),
    .CPU_IDLE(st[6]), .POWER_MODE_0(st[4]), .HALT_BY_BREAKPOINT(st[3]),
    .DEBUG_LOCK_BIT(st[2]), .OSC_STABLE(st[1]), .STACK_OVERFLOW(st[0]),
    .ERASE_DONE(st[7]), .ERASE_REQ(req[6]), .HALT_REQ(req[5]),
    .RESUME_REQ(req[4]), .INJECT_REQ(req[3]), .STEP_REQ(req[2]),
    .SUBST_REQ(req[1]), .BRK_SET_REQ(req[0]), .CPU_INSTR(ins),
    .CPU_INSTR_LEN(ilen), .BRK_DATA(brk), .TIMERS_STOP(cfg[3]),
    .DMA_PAUSE(cfg[2]), .TIMER_SUSPEND(cfg[1]), .INFO_PAGE_SELECT(cfg[0]));
  dcd_host dcd_host_i (.clk(clk), .oe(oe), .dout(dout), .dbg_clk(dclk),
    .dbg_data(ddat));
  task automatic chk(input [47:0] nm, input [23:0] e, input [23:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // Runs one command and compares the request pulses it raised
  task automatic run(input [7:0] c, input [23:0] op, input integer n,
                     input [6:0] e);
    clr = 1;
    @(posedge clk);
    #1 clr = 0;
    dcd_host_i.cmd(c, op, n, r);
    chk("reqs", e, seen);
  endtask
  task give_verdict;
    $display("Mismatches %0d, checks %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    give_verdict;
  end
  initial begin
    i = $urandom(32'h368b);
    repeat (10) @(posedge clk);
    #1 rst = 0;
    st = $urandom & 8'hfb;
    run(8'h34, 0, 1, 0);
    chk("status", st, r[7:0]);
    run(8'h14, 0, 1, 7'h40);
    run(8'h24, 0, 1, 0);
    chk("cfg0", 0, r[7:0]);
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 24'hff0000 : $urandom;
      run(i[0] ? 8'h1d : 8'h19, v, i[0], 0);
      chk("cfgout", v[19:16], cfg);
      run(8'h24, 0, 1, 0);
      chk("rdcfg", {4'h0, v[19:16]}, r[7:0]);
    end
    run(8'h10, 0, 0, 0);
    run(8'h19, 24'h0f0000, 0, 0);
    chk("cfgpre", 4'hf, cfg);
    rst = 1;
    repeat (4) @(posedge clk);
    #1 rst = 0;
    chk("cfgrst", 0, cfg);
    run(8'h10, 0, 0, 7'h40);
    run(8'h24, 0, 1, 0);
    chk("rdrst", 0, r[7:0]);
    pc = $urandom;
    run(8'h28, 0, 2, 0);
    chk("pc", pc, r);
    run(8'h68, 0, 2, 0);
    chk("id", ID, r);
    for (i = 0; i < 2; i++) begin
      st = {2'b00, i[0], 5'h02};
      v = $urandom;
      run(8'h4c, 0, 1, {2'b0, i[0], 4'h0});
      chk("resans", st, r[7:0]);
      run(8'h5c, 0, 1, {4'h0, i[0], 2'h0});
      run(8'h55, v, 1, {3'h0, i[0], 3'h0});
      if (i == 1) chk("inj", {v[23:16], 2'd1}, {ins[23:16], ilen});
      run(8'h67, v, 1, {5'h0, i[0], 1'b0});
      if (i == 1) chk("subst", {v, 2'd3}, {ins, ilen});
      run(8'h3f, v, 1, 7'h01);
      chk("brk", v, brk);
    end
    run(8'h44, 0, 1, 7'h20);
    st = 8'h24;
    run(8'h44, 0, 1, 0);
    run(8'h34, 0, 1, 0);
    chk("locked", st, r[7:0]);
    run(8'h68, 0, 2, 0);
    chk("id2", ID, r);
    give_verdict;
  end
endmodule
